//--- core/ctsu_pkg.sv
// Purpose: Shared constants and types for the condition test and successor unit.
// Assumes: Instruction bit n of the printed format is instr_word[12-n].

package ctsu_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int INSTR_W = 12;
  localparam int ADDER_W = 8;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  localparam int CMD_HI = 2;
  localparam int CMD_LO = 0;
  localparam int COND_HI = 11;
  localparam int COND_LO = 9;
  localparam int SETF_HI = 8;
  localparam int SETF_LO = 7;
  localparam int TRUE_HI = 6;
  localparam int TRUE_LO = 5;
  localparam int FALSE_HI = 4;
  localparam int FALSE_LO = 3;
  localparam logic [2:0] CMD_CTEST = 3'h7;

  localparam logic [2:0] COND_MSB = 3'h0;
  localparam logic [2:0] COND_CARRY = 3'h1;
  localparam logic [2:0] COND_LSB = 3'h2;
  localparam logic [2:0] COND_ONES = 3'h3;
  localparam logic [2:0] COND_LF1 = 3'h4;
  localparam logic [2:0] COND_LF2 = 3'h5;
  localparam logic [2:0] COND_LF3 = 3'h6;
  localparam logic [2:0] COND_ATTN = 3'h7;

  localparam logic [1:0] SET_LF1 = 2'h0;
  localparam logic [1:0] SET_LF2 = 2'h1;
  localparam logic [1:0] SET_LF3 = 2'h2;
  localparam logic [1:0] SET_NONE = 2'h3;

  localparam logic [1:0] SUCC_JUMP = 2'h0;
  localparam logic [1:0] SUCC_STEP = 2'h1;
  localparam logic [1:0] SUCC_SKIP = 2'h2;
  localparam logic [1:0] SUCC_SAVE = 2'h3;

  localparam logic [ADDR_W-1:0] PC_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ALT_RESET = 8'h00;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam int CTRL_ATTN_EN_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_ATTN_EN_RESET = 1'b1;
  localparam int ST_PC_LO = 0;
  localparam int ST_ALT_LO = 8;
  localparam int ST_COND_LO = 16;
  localparam int ST_RESULT_BIT = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_WRESP = 3'h2,
    BUS_RRESP = 3'h4
  } bus_state_t;

endpackage

//--- core/next_address_select.sv
// Purpose: Next counter and alternate address for one successor code.
// Assumes: Counter wraps modulo the address space.
// Notes:   Purely combinational; caller registers the result.

`timescale 1ns/1ps
`default_nettype none

module next_address_select #(
  parameter int W = ctsu_pkg::ADDR_W
) (
  input wire logic [W-1:0] cur_pc,
  input wire logic [W-1:0] cur_alt,
  input wire logic [1:0] code,
  output logic [W-1:0] nxt_pc,
  output logic [W-1:0] nxt_alt
);

  always_comb begin
    nxt_pc = W'(cur_pc + 1'b1);
    nxt_alt = cur_alt;
    case (code)
      ctsu_pkg::SUCC_STEP: begin
        nxt_pc = W'(cur_pc + 1'b1);
      end
      ctsu_pkg::SUCC_SKIP: begin
        nxt_pc = W'(cur_pc + W'(2));
      end
      ctsu_pkg::SUCC_SAVE: begin
        nxt_pc = W'(cur_pc + 1'b1);
        nxt_alt = W'(cur_pc + 1'b1);
      end
      ctsu_pkg::SUCC_JUMP: begin
        nxt_pc = cur_alt;
      end
      default: begin
        nxt_pc = W'(cur_pc + 1'b1);
      end
    endcase
  end

endmodule

`default_nettype wire

//--- core/adder_flag_capture.sv
// Purpose: Capture the four adder condition flags from the serial result.
// Assumes: One result bit per strobe, least significant bit first.
// Notes:   Flags move only when a full word has been seen.

`timescale 1ns/1ps
`default_nettype none

module adder_flag_capture #(
  parameter int W = ctsu_pkg::ADDER_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic carry_in,
  input wire logic restart,
  output logic result_msb_flag,
  output logic result_lsb_flag,
  output logic all_ones_flag,
  output logic serial_carry_flag
);

  typedef struct packed {
    logic [7:0] cnt;
    logic run_lsb;
    logic run_ones;
    logic f_msb;
    logic f_lsb;
    logic f_ones;
    logic f_carry;
  } flag_state_t;

  flag_state_t st_ff;
  flag_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (restart) begin
      // Partial word dropped; finished flags are kept
      nxt_st.cnt = 8'h00;
    end else if (bit_valid) begin
      if (st_ff.cnt == 8'h00) begin
        nxt_st.run_lsb = bit_in;
        nxt_st.run_ones = bit_in;
      end else begin
        nxt_st.run_ones = st_ff.run_ones & bit_in;
      end
      if (st_ff.cnt == 8'(W - 1)) begin
        nxt_st.cnt = 8'h00;
        nxt_st.f_lsb = (W == 1) ? bit_in : st_ff.run_lsb;
        nxt_st.f_msb = bit_in;
        nxt_st.f_ones = st_ff.run_ones & bit_in;
        nxt_st.f_carry = carry_in;
      end else begin
        nxt_st.cnt = 8'(st_ff.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign result_msb_flag = st_ff.f_msb;
  assign result_lsb_flag = st_ff.f_lsb;
  assign all_ones_flag = st_ff.f_ones;
  assign serial_carry_flag = st_ff.f_carry;

  flags_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !bit_valid |=> $stable({st_ff.f_msb, st_ff.f_lsb, st_ff.f_ones, st_ff.f_carry}))
    else $error("adder flags moved without a result bit");

  msb_last_bit_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (bit_valid && !restart && st_ff.cnt == 8'(W - 1)) |=> (st_ff.f_msb == $past(bit_in)))
    else $error("msb flag is not the last result bit");

endmodule

`default_nettype wire

//--- core/condition_test_successor_unit.sv
// Purpose: Condition test, local flags and successor address of the control unit.
// Assumes: Instruction, adder and attention inputs are synchronous to ref_clk.
// Notes:   Software sees control and status over an AXI4-Lite slave.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.

`timescale 1ns/1ps
`default_nettype none

module condition_test_successor_unit (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [11:0] instr_word,
  input wire logic alt_load_valid,
  input wire logic [7:0] alt_load_data,
  input wire logic alt_load_jump,
  input wire logic adder_bit_valid,
  input wire logic adder_bit,
  input wire logic adder_carry,
  input wire logic adder_restart,
  input wire logic external_attention,
  input wire logic counter_clear_input,
  output logic [7:0] fetch_addr,
  output logic [7:0] alt_addr,
  output logic cond_result,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ctsu_pkg::bus_state_t bus;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic attn_en;
    logic clr_pulse;
    logic [7:0] program_address_counter;
    logic [7:0] alternate_address_register;
    logic local_flag_one;
    logic local_flag_two;
    logic local_flag_three;
    logic attn_pending;
    logic last_result;
  } unit_state_t;

  unit_state_t st_ff;
  unit_state_t nxt_st;

  logic result_msb_flag;
  logic result_lsb_flag;
  logic all_ones_flag;
  logic serial_carry_flag;
  logic is_ctest;
  logic [2:0] cond_sel;
  logic [1:0] set_sel;
  logic [7:0] cond_vec;
  logic cond_true;
  logic [1:0] succ_code;
  logic clr_now;
  logic [7:0] sel_pc;
  logic [7:0] sel_alt;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign is_ctest = instr_word[ctsu_pkg::CMD_HI:ctsu_pkg::CMD_LO] == ctsu_pkg::CMD_CTEST;
  assign cond_sel = instr_word[ctsu_pkg::COND_HI:ctsu_pkg::COND_LO];
  assign set_sel = instr_word[ctsu_pkg::SETF_HI:ctsu_pkg::SETF_LO];

  // Index order matches the condition select codes
  assign cond_vec = {st_ff.attn_pending, st_ff.local_flag_three, st_ff.local_flag_two,
                     st_ff.local_flag_one, all_ones_flag, result_lsb_flag,
                     serial_carry_flag, result_msb_flag};
  assign cond_true = cond_vec[cond_sel];

  // Non-test instructions fall through as STEP
  assign succ_code = !is_ctest ? ctsu_pkg::SUCC_STEP :
                     cond_true ? instr_word[ctsu_pkg::TRUE_HI:ctsu_pkg::TRUE_LO] :
                     instr_word[ctsu_pkg::FALSE_HI:ctsu_pkg::FALSE_LO];
  assign clr_now = counter_clear_input | st_ff.clr_pulse;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  next_address_select #(
    .W(ctsu_pkg::ADDR_W)
  ) u_next (
    .cur_pc(st_ff.program_address_counter),
    .cur_alt(st_ff.alternate_address_register),
    .code(succ_code),
    .nxt_pc(sel_pc),
    .nxt_alt(sel_alt)
  );

  // Literal loads never reach this path, so flags stay put
  adder_flag_capture #(
    .W(ctsu_pkg::ADDER_W)
  ) u_flags (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .bit_valid(adder_bit_valid),
    .bit_in(adder_bit),
    .carry_in(adder_carry),
    .restart(adder_restart),
    .result_msb_flag(result_msb_flag),
    .result_lsb_flag(result_lsb_flag),
    .all_ones_flag(all_ones_flag),
    .serial_carry_flag(serial_carry_flag)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.clr_pulse = 1'b0;

    // Bus slave: write halves may land in either order
    case (st_ff.bus)
      ctsu_pkg::BUS_IDLE: begin
        if (s_axi_awvalid && st_ff.awready) begin
          nxt_st.aw_got = 1'b1;
          nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
          nxt_st.w_got = 1'b1;
          nxt_st.w_data = s_axi_wdata;
          nxt_st.w_strb = s_axi_wstrb;
        end
        if (s_axi_arvalid && st_ff.arready) begin
          nxt_st.bus = ctsu_pkg::BUS_RRESP;
          nxt_st.rvalid = 1'b1;
          nxt_st.rresp = ctsu_pkg::RESP_OKAY;
          nxt_st.rdata = 32'h0000_0000;
          if (s_axi_araddr == ctsu_pkg::REG_CTRL) begin
            nxt_st.rdata[ctsu_pkg::CTRL_ATTN_EN_BIT] = st_ff.attn_en;
          end else if (s_axi_araddr == ctsu_pkg::REG_STATUS) begin
            nxt_st.rdata[ctsu_pkg::ST_PC_LO +: 8] = st_ff.program_address_counter;
            nxt_st.rdata[ctsu_pkg::ST_ALT_LO +: 8] = st_ff.alternate_address_register;
            nxt_st.rdata[ctsu_pkg::ST_COND_LO +: 8] = cond_vec;
            nxt_st.rdata[ctsu_pkg::ST_RESULT_BIT] = st_ff.last_result;
          end else begin
            nxt_st.rresp = ctsu_pkg::RESP_SLVERR;
          end
        end else if (nxt_st.aw_got && nxt_st.w_got) begin
          nxt_st.bus = ctsu_pkg::BUS_WRESP;
          nxt_st.bvalid = 1'b1;
          nxt_st.aw_got = 1'b0;
          nxt_st.w_got = 1'b0;
          nxt_st.bresp = ctsu_pkg::RESP_OKAY;
          if (nxt_st.aw_addr == ctsu_pkg::REG_CTRL) begin
            if (nxt_st.w_strb[0]) begin
              nxt_st.attn_en = nxt_st.w_data[ctsu_pkg::CTRL_ATTN_EN_BIT];
              nxt_st.clr_pulse = nxt_st.w_data[ctsu_pkg::CTRL_CLEAR_BIT];
            end
          end else if (nxt_st.aw_addr != ctsu_pkg::REG_STATUS) begin
            nxt_st.bresp = ctsu_pkg::RESP_SLVERR;
          end
        end
      end
      ctsu_pkg::BUS_WRESP: begin
        if (s_axi_bready) begin
          nxt_st.bvalid = 1'b0;
          nxt_st.bus = ctsu_pkg::BUS_IDLE;
        end
      end
      ctsu_pkg::BUS_RRESP: begin
        if (s_axi_rready) begin
          nxt_st.rvalid = 1'b0;
          nxt_st.bus = ctsu_pkg::BUS_IDLE;
        end
      end
      default: begin
        nxt_st.bus = ctsu_pkg::BUS_IDLE;
        nxt_st.bvalid = 1'b0;
        nxt_st.rvalid = 1'b0;
      end
    endcase
    nxt_st.awready = (nxt_st.bus == ctsu_pkg::BUS_IDLE) && !nxt_st.aw_got;
    nxt_st.wready = (nxt_st.bus == ctsu_pkg::BUS_IDLE) && !nxt_st.w_got;
    // A finished write half pair goes first
    nxt_st.arready = (nxt_st.bus == ctsu_pkg::BUS_IDLE) && !(nxt_st.aw_got && nxt_st.w_got);

    // Sequencer
    if (instr_valid) begin
      nxt_st.program_address_counter = sel_pc;
      nxt_st.alternate_address_register = sel_alt;
      if (is_ctest) begin
        nxt_st.last_result = cond_true;
        case (cond_sel)
          ctsu_pkg::COND_LF1: nxt_st.local_flag_one = 1'b0;
          ctsu_pkg::COND_LF2: nxt_st.local_flag_two = 1'b0;
          ctsu_pkg::COND_LF3: nxt_st.local_flag_three = 1'b0;
          ctsu_pkg::COND_ATTN: nxt_st.attn_pending = 1'b0;
          default: begin
          end
        endcase
        // Set after clear so a set of the tested flag wins
        if (cond_true) begin
          case (set_sel)
            ctsu_pkg::SET_LF1: nxt_st.local_flag_one = 1'b1;
            ctsu_pkg::SET_LF2: nxt_st.local_flag_two = 1'b1;
            ctsu_pkg::SET_LF3: nxt_st.local_flag_three = 1'b1;
            default: begin
            end
          endcase
        end
      end
    end
    if (alt_load_valid) begin
      nxt_st.alternate_address_register = alt_load_data;
      if (alt_load_jump) begin
        nxt_st.program_address_counter = alt_load_data;
      end
    end
    // A held level re-arms at once; the clear only drops a gone level
    if (external_attention && st_ff.attn_en) begin
      nxt_st.attn_pending = 1'b1;
    end
    if (clr_now) begin
      nxt_st.program_address_counter = ctsu_pkg::PC_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
      st_ff.bus <= ctsu_pkg::BUS_IDLE;
      st_ff.attn_en <= ctsu_pkg::CTRL_ATTN_EN_RESET;
      st_ff.program_address_counter <= ctsu_pkg::PC_RESET;
      st_ff.alternate_address_register <= ctsu_pkg::ALT_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign fetch_addr = st_ff.program_address_counter;
  assign alt_addr = st_ff.alternate_address_register;
  assign cond_result = st_ff.last_result;
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rvalid = st_ff.rvalid;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  step_advance_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (instr_valid && !is_ctest && !alt_load_valid && !clr_now)
      |=> (fetch_addr == 8'($past(fetch_addr) + 1'b1)))
    else $error("plain instruction did not step by one");

  skip_by_two_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (instr_valid && is_ctest && succ_code == ctsu_pkg::SUCC_SKIP && !alt_load_valid && !clr_now)
      |=> (fetch_addr == 8'($past(fetch_addr) + 8'h02)) && $stable(alt_addr))
    else $error("skip did not advance by two");

  jump_target_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (instr_valid && is_ctest && succ_code == ctsu_pkg::SUCC_JUMP && !alt_load_valid && !clr_now)
      |=> (fetch_addr == $past(alt_addr)) && $stable(alt_addr))
    else $error("jump did not load the alternate address");

  save_both_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (instr_valid && is_ctest && succ_code == ctsu_pkg::SUCC_SAVE && !alt_load_valid && !clr_now)
      |=> (alt_addr == fetch_addr) && (fetch_addr == 8'($past(fetch_addr) + 1'b1)))
    else $error("save did not load both addresses");

  true_field_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (instr_valid && is_ctest && cond_true)
      |-> (succ_code == instr_word[ctsu_pkg::TRUE_HI:ctsu_pkg::TRUE_LO]))
    else $error("true condition used the wrong successor field");

  clear_counter_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    counter_clear_input |=> (fetch_addr == ctsu_pkg::PC_RESET))
    else $error("clear input did not zero the counter");

  lflag_clear_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (instr_valid && is_ctest && cond_sel == ctsu_pkg::COND_LF1
      && !(cond_true && set_sel == ctsu_pkg::SET_LF1))
      |=> !st_ff.local_flag_one)
    else $error("tested local flag was not cleared");

  lflag_set_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (instr_valid && is_ctest && set_sel == ctsu_pkg::SET_LF2)
      |=> (st_ff.local_flag_two == ($past(cond_true) || $past(st_ff.local_flag_two)
           && $past(cond_sel) != ctsu_pkg::COND_LF2)))
    else $error("set field misapplied to local flag two");

  bresp_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");

  false_step_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (instr_valid && is_ctest && !cond_true && !alt_load_valid && !clr_now
      && instr_word[ctsu_pkg::FALSE_HI:ctsu_pkg::FALSE_LO] == ctsu_pkg::SUCC_STEP)
      |=> (fetch_addr == 8'($past(fetch_addr) + 1'b1)) && $stable(alt_addr))
    else $error("false condition did not take the false step");

  attn_clear_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (instr_valid && is_ctest && cond_sel == ctsu_pkg::COND_ATTN
      && !(external_attention && st_ff.attn_en))
      |=> !st_ff.attn_pending)
    else $error("tested attention was not cleared");

endmodule

`default_nettype wire

//--- test/far_side_model.sv
// Purpose: Serial adder and attention source facing the unit.
// Assumes: start is a one-cycle pulse; one word at a time.
// Notes:   Lines carry junk outside a word, as the real adder may.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic ref_clk,
  input wire logic start,
  input wire logic [7:0] word,
  input wire logic carry,
  input wire logic attn_req,
  output logic adder_bit_valid,
  output logic adder_bit,
  output logic adder_carry,
  output logic external_attention
);
  logic [7:0] sh;
  logic [3:0] cnt;
  logic cy;
  initial begin
    {adder_bit_valid, adder_bit, adder_carry, cy, cnt, sh} = '0;
  end
  // Attention is a plain level from outside
  assign external_attention = attn_req;
  always @(posedge ref_clk) begin
    if (start) begin
      sh <= word;
      cy <= carry;
      cnt <= 4'h8;
      adder_bit_valid <= 1'b0;
    end else if (cnt != 4'h0) begin
      adder_bit_valid <= 1'b1;
      adder_bit <= sh[0];
      sh <= sh >> 1;
      cnt <= cnt - 4'h1;
      adder_carry <= (cnt == 4'h1) ? cy : ~cy;
    end else begin
      adder_bit_valid <= 1'b0;
      adder_bit <= ~adder_bit;
      adder_carry <= ~adder_carry;
    end
  end
endmodule
`default_nettype wire

//--- test/condition_test_successor_unit_tb_top.sv
// Purpose: Self-checking bench for the condition test and successor unit.
// Assumes: Design flops update by non-blocking assignment.
// Notes:   exp_pc and exp_alt track the counter and alternate address.
`timescale 1ns/1ps
`default_nettype none
module condition_test_successor_unit_tb_top;
  logic ref_clk, rstn, instr_valid, alt_load_valid, alt_load_jump, counter_clear_input;
  logic [11:0] instr_word;
  logic [7:0] alt_load_data, fetch_addr, alt_addr, s_axi_awaddr, s_axi_araddr;
  logic [7:0] exp_pc, exp_alt, a_word;
  logic cond_result, adder_bit_valid, adder_bit, adder_carry, external_attention;
  logic start, a_carry, attn_req;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] af;
  int bad_count, checks, cyc;
  condition_test_successor_unit dut (.ref_clk, .rstn, .instr_valid, .instr_word,
    .alt_load_valid, .alt_load_data, .alt_load_jump, .adder_bit_valid, .adder_bit,
    .adder_carry, .adder_restart(1'b0), .external_attention, .counter_clear_input,
    .fetch_addr, .alt_addr, .cond_result, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  far_side_model far (.ref_clk, .start, .word(a_word), .carry(a_carry), .attn_req,
    .adder_bit_valid, .adder_bit, .adder_carry, .external_attention);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic exec(input logic [11:0] w);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic ct(input logic [2:0] c, input logic [1:0] s, t, f, input logic e);
    exec({c, s, t, f, 3'h7});
    case (e ? t : f)
      ctsu_pkg::SUCC_STEP: exp_pc = exp_pc + 8'h01;
      ctsu_pkg::SUCC_SKIP: exp_pc = exp_pc + 8'h02;
      ctsu_pkg::SUCC_SAVE: begin
        exp_pc = exp_pc + 8'h01;
        exp_alt = exp_pc;
      end
      default: exp_pc = exp_alt;
    endcase
    cmp(fetch_addr, exp_pc);
    cmp(alt_addr, exp_alt);
    cmp(cond_result, e);
  endtask
  task automatic feed(input logic [7:0] w, input logic c);
    @(posedge ref_clk);
    start <= 1'b1;
    a_word <= w;
    a_carry <= c;
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (12) @(posedge ref_clk);
    af = {&w, w[0], c, w[7]};
  endtask
  task automatic round();
    for (int i = 0; i < 4; i++) begin
      ct(i[2:0], ctsu_pkg::SET_NONE, ctsu_pkg::SUCC_SKIP, ctsu_pkg::SUCC_STEP, af[i]);
    end
  endtask
  task automatic alt_ld(input logic [7:0] d);
    @(posedge ref_clk);
    alt_load_valid <= 1'b1;
    alt_load_jump <= 1'b1;
    alt_load_data <= d;
    @(posedge ref_clk);
    alt_load_valid <= 1'b0;
    exp_alt = d;
    exp_pc = d;
    #1 cmp(alt_addr, exp_alt);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, timeout and tests
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    {rstn, instr_valid, alt_load_valid, alt_load_jump, counter_clear_input} = '0;
    {start, a_carry, attn_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, instr_word, alt_load_data, a_word} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, exp_pc, exp_alt, af} = '0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    #1 cmp(fetch_addr, 8'h00);
    feed(8'hFF, 1'b1);
    round();
    round();
    for (int s = 0; s < 3; s++) begin
      ct(ctsu_pkg::COND_MSB, s[1:0], 2'h1, 2'h0, 1'b1);
      ct(3'h4 + s[2:0], ctsu_pkg::SET_NONE, 2'h3, 2'h2, 1'b1);
      ct(3'h4 + s[2:0], ctsu_pkg::SET_NONE, 2'h3, 2'h1, 1'b0);
    end
    ct(ctsu_pkg::COND_ONES, ctsu_pkg::SET_NONE, 2'h3, 2'h1, 1'b1);
    for (int s = 0; s < 3; s++) ct(3'h4 + s[2:0], 2'h3, 2'h1, 2'h2, 1'b0);
    feed(8'h01, 1'b0);
    round();
    feed(8'h80, 1'b1);
    round();
    ct(ctsu_pkg::COND_LSB, ctsu_pkg::SET_LF3, 2'h1, 2'h2, 1'b0);
    ct(ctsu_pkg::COND_LF3, ctsu_pkg::SET_NONE, 2'h2, 2'h1, 1'b0);
    alt_ld(8'h5A);
    round();
    ct(ctsu_pkg::COND_MSB, ctsu_pkg::SET_NONE, 2'h0, 2'h1, 1'b1);
    ct(ctsu_pkg::COND_LSB, ctsu_pkg::SET_NONE, 2'h1, 2'h0, 1'b0);
    alt_ld(8'hFE);
    ct(ctsu_pkg::COND_CARRY, ctsu_pkg::SET_NONE, 2'h2, 2'h2, 1'b1);
    exec(12'hC06);
    exp_pc = exp_pc + 8'h01;
    cmp(fetch_addr, exp_pc);
    @(posedge ref_clk) attn_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ct(ctsu_pkg::COND_ATTN, ctsu_pkg::SET_NONE, 2'h1, 2'h2, 1'b1);
    @(posedge ref_clk) attn_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ct(ctsu_pkg::COND_ATTN, ctsu_pkg::SET_NONE, 2'h1, 2'h2, 1'b1);
    ct(ctsu_pkg::COND_ATTN, ctsu_pkg::SET_NONE, 2'h1, 2'h2, 1'b0);
    @(posedge ref_clk) counter_clear_input <= 1'b1;
    @(posedge ref_clk) counter_clear_input <= 1'b0;
    exp_pc = 8'h00;
    #1 cmp(fetch_addr, exp_pc);
    axr(ctsu_pkg::REG_STATUS);
    cmp(rd[24:0], {9'h003, exp_alt, exp_pc});
    cmp(rsp, ctsu_pkg::RESP_OKAY);
    axr(8'h08);
    cmp(rsp, ctsu_pkg::RESP_SLVERR);
    cmp(rd, 32'h0000_0000);
    axw(8'h0C, 32'h0000_0003);
    cmp(rsp, ctsu_pkg::RESP_SLVERR);
    axw(ctsu_pkg::REG_CTRL, 32'h0000_0000);
    cmp(rsp, ctsu_pkg::RESP_OKAY);
    @(posedge ref_clk) attn_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ct(ctsu_pkg::COND_ATTN, ctsu_pkg::SET_NONE, 2'h1, 2'h2, 1'b0);
    @(posedge ref_clk) attn_req <= 1'b0;
    axw(ctsu_pkg::REG_CTRL, 32'h0000_0003);
    repeat (3) @(posedge ref_clk);
    exp_pc = 8'h00;
    #1 cmp(fetch_addr, exp_pc);
    report_and_stop();
  end
endmodule
`default_nettype wire
